// File: common/nv_prog_map.svh
/*
  Constants of the serial programming engine: command codes, core opcodes,
  special register addresses, control bit positions, bus offsets, timing.
  Assumes inclusion by bare name from any file that needs them.
*/
// How it works
// - Data EEPROM is written a byte at a time via address pair and data latch.
// - A byte write overwrites the location; no separate erase is required.
// - Write enable bit 2 must be set first; with it clear, no write starts.
// - Setting write-start bit 1 of the control register starts a write.
// - The write begins on the fourth serial clock fall after write-start is set.
// - Hardware clears write-start at the end; it reads set while busy.
// - Polling copies control into the table latch; shift-out returns it serially.
// - Identification bytes sit at table addresses 200000h to 200007h.
// - Identification bytes read back truly regardless of code protection.
// - Table writes load two bytes; 1101 advances by two, 1111 starts programming.
// - Four-bit commands shift in least significant bit first on the clock.
`ifndef NV_PROG_MAP_SVH
`define NV_PROG_MAP_SVH

// ****************************************************************
// Link commands and counts
// ****************************************************************
`define CMD_CORE        4'h0
`define CMD_SHIFT_OUT   4'h2
`define CMD_TBL_RD_INC  4'h9
`define CMD_TBL_WR_INC2 4'hD
`define CMD_TBL_WR_PROG 4'hF
`define CMD_LAST        4'h3
`define PAYLOAD_LAST    4'hF
`define HALF_LAST       4'h7
`define WR_START_FALLS  3'h4

// ****************************************************************
// Core opcodes and special register addresses
// ****************************************************************
`define OP_MOVLW   8'h0E
`define OP_MOVWF   8'h6E
`define OP_MOVF    8'h50
`define OP_BSF     4'h8
`define OP_BCF     4'h9
`define SFR_CTRL   8'hA6
`define SFR_DATA   8'hA8
`define SFR_ADDR_L 8'hA9
`define SFR_ADDR_H 8'hAA
`define SFR_TABLE_LATCH 8'hF5
`define SFR_TP_L   8'hF6
`define SFR_TP_H   8'hF7
`define SFR_TP_U   8'hF8

// ****************************************************************
// Control bits, memories, bus map, timing
// ****************************************************************
`define CTRL_PGM    7
`define CTRL_CFG    6
`define CTRL_WRITE_ENABLE_BIT   2
`define CTRL_WR     1
`define CTRL_RD     0
`define CTRL_RESET  8'h00
`define SEL_DATA_EE 2'h0
`define EE_ADDR_W   10
`define ID_ADDR_W   3
`define ID_BASE_TAG 19'h40000
`define TP_STEP2    22'h000002
`define TP_STEP1    22'h000001
`define REG_CTRL    8'h00
`define REG_EE_ADDR 8'h04
`define REG_EE_DATA 8'h08
`define REG_TBLPTR  8'h0C
`define BIT_LINK_ON 0
`define EE_WRITE_NS 4000000
`define REF_CLK_NS  40

`endif

// File: common/nv_prog_pkg.sv
/*
  Types of the serial programming engine.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package nv_prog_pkg;

  // Serial shift engine phases
  typedef enum logic [1:0] {
    ST_CMD     = 2'b00,
    ST_PAYLOAD = 2'b01,
    ST_DUMMY   = 2'b10,
    ST_OUT     = 2'b11
  } shift_state_t;

  // Data EEPROM write sequencer
  typedef enum logic [1:0] {
    WS_IDLE = 2'b00,
    WS_WAIT = 2'b01,
    WS_BUSY = 2'b10
  } wr_state_t;

endpackage

// File: common/nv_mem_if.sv
/*
  Port of a byte memory: write strobe, address, write data, registered read.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none

interface nv_mem_if #(parameter int AW = 8);
  logic          we;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  modport host (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// File: design/nv_byte_mem.sv
/*
  Single port byte memory with registered read data.
  Assumes the owner keeps the address stable one cycle before using rdata.
*/
`timescale 1ns/10ps
`default_nettype none

module nv_byte_mem #(
  parameter int AW = 8                  // Address width
) (
  input  wire logic i_clk,              // Reference clock
  nv_mem_if.mem     port                // Memory port
);

  logic [7:0] mem_q [1 << AW];

  // Write overwrites the old byte outright, read is registered
  always_ff @(posedge i_clk) begin
    if (port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
    port.rdata <= mem_q[port.addr];
  end

endmodule

`default_nettype wire

// File: design/nv_prog_core.sv
/*
  Serial programming engine: command shifter, core instruction subset,
  data EEPROM write sequencer, identification write buffer, Avalon slave.
  Assumes the programming clock and data pins are asynchronous to i_ref_clk
  and that the link clock is far slower than i_ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "nv_prog_map.svh"

module nv_prog_core
  import nv_prog_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `EE_WRITE_NS / `REF_CLK_NS  // Self-timed write length
) (
  input  wire logic        i_ref_clk,        // 25 MHz clock
  input  wire logic        i_rst_n,          // Async reset, active low
  input  wire logic        i_prog_serial_clock, // Link clock pin
  input  wire logic        i_prog_serial_data,  // Link data pin, input side
  output logic             o_prog_serial_data,  // Link data pin, output side
  output logic             o_prog_serial_data_oe, // High while driving data
  input  wire logic [7:0]  i_avs_address,    // Byte address
  input  wire logic        i_avs_read,       // Read request
  input  wire logic        i_avs_write,      // Write request
  input  wire logic [31:0] i_avs_writedata,  // Write data
  output logic [31:0]      o_avs_readdata,   // Read data
  output logic             o_avs_waitrequest // Stall
);

  localparam int TMR_W = $clog2(WRITE_CYCLES + 1);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] clk_sync_q;
  logic [2:0] dat_sync_q;
  logic       clk_lvl_q;
  logic       dat_lvl_q;
  logic       clk_lvl_d;
  logic       dat_lvl_d;
  logic       link_on_q;
  logic       pgc_fall;
  logic       pgc_rise;

  // A change counts only once the second and third stages agree
  assign clk_lvl_d = (clk_sync_q[2] == clk_sync_q[1]) ? clk_sync_q[2] : clk_lvl_q;
  assign dat_lvl_d = (dat_sync_q[2] == dat_sync_q[1]) ? dat_sync_q[2] : dat_lvl_q;
  assign pgc_fall  = clk_lvl_q & ~clk_lvl_d & link_on_q;
  assign pgc_rise  = ~clk_lvl_q & clk_lvl_d & link_on_q;

  // Three-stage capture of both pins
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_sync_q <= 3'h0;
      dat_sync_q <= 3'h0;
      clk_lvl_q  <= 1'b0;
      dat_lvl_q  <= 1'b0;
    end else begin
      clk_sync_q <= {clk_sync_q[1:0], i_prog_serial_clock};
      dat_sync_q <= {dat_sync_q[1:0], i_prog_serial_data};
      clk_lvl_q  <= clk_lvl_d;
      dat_lvl_q  <= dat_lvl_d;
    end
  end

  // ****************************************************************
  // Command and payload shifter
  // ****************************************************************
  shift_state_t st_q;
  shift_state_t st_d;
  logic [3:0]   cnt_q;
  logic [3:0]   cnt_d;
  logic [3:0]   cmd_q;
  logic [15:0]  sh_q;
  logic [7:0]   out_q;
  logic [7:0]   out_byte;
  logic         sd_q;
  logic         oe_q;
  logic [3:0]   cmd_w;
  logic [15:0]  pay_w;
  logic         bit_last;
  logic         rd_cmd;
  logic         pay_done;
  logic         dummy_done;
  logic         out_done;

  // Bits arrive least significant first on each falling clock edge
  assign cmd_w      = {dat_lvl_q, cmd_q[3:1]};
  assign pay_w      = {dat_lvl_q, sh_q[15:1]};
  assign bit_last   = (st_q == ST_CMD)     ? (cnt_q == `CMD_LAST) :
                      (st_q == ST_PAYLOAD) ? (cnt_q == `PAYLOAD_LAST) :
                                             (cnt_q == `HALF_LAST);
  assign rd_cmd     = (cmd_w == `CMD_SHIFT_OUT) || (cmd_w == `CMD_TBL_RD_INC);
  assign pay_done   = pgc_fall && (st_q == ST_PAYLOAD) && bit_last;
  assign dummy_done = pgc_fall && (st_q == ST_DUMMY) && bit_last;
  assign out_done   = pgc_fall && (st_q == ST_OUT) && bit_last;

  // Phase sequencing; reads take 8 dummy clocks then 8 output clocks
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    if (!link_on_q) begin
      st_d  = ST_CMD;
      cnt_d = 4'h0;
    end else if (pgc_fall) begin
      cnt_d = bit_last ? 4'h0 : cnt_q + 4'h1;
      if (bit_last) begin
        case (st_q)
          ST_CMD:     st_d = rd_cmd ? ST_DUMMY : ST_PAYLOAD;
          ST_PAYLOAD: st_d = ST_CMD;
          ST_DUMMY:   st_d = ST_OUT;
          ST_OUT:     st_d = ST_CMD;
          default:    st_d = ST_CMD;
        endcase
      end
    end
  end

  // Shift registers and the data pin driver
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q  <= ST_CMD;
      cnt_q <= 4'h0;
      cmd_q <= 4'h0;
      sh_q  <= 16'h0000;
      out_q <= 8'h00;
      sd_q  <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      if (pgc_fall && st_q == ST_CMD) begin
        cmd_q <= cmd_w;
      end
      if (pgc_fall && st_q == ST_PAYLOAD) begin
        sh_q <= pay_w;
      end
      if (dummy_done) begin
        out_q <= out_byte;
        oe_q  <= 1'b1;
      end else if (pgc_rise && st_q == ST_OUT) begin
        sd_q  <= out_q[0];
        out_q <= {1'b0, out_q[7:1]};
      end else if (out_done || !link_on_q) begin
        oe_q  <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Core instruction subset
  // ****************************************************************
  logic [7:0]  w_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [7:0]  addr_lo_q;
  logic [1:0]  addr_hi_q;
  logic [7:0]  data_q;
  logic [7:0]  table_latch_q;
  logic [21:0] ptr_q;
  logic [7:0]  sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  bit_mask;
  logic [7:0]  f_adr;
  logic        is_core;
  logic        do_movlw;
  logic        do_movwf;
  logic        do_movf;
  logic        do_bsf;
  logic        do_bcf;
  logic        sfr_we;
  logic        ctrl_sw;
  logic        ee_sel;
  logic        wr_set;
  logic        wr_done;
  logic        rd_go;
  logic        rd_pend_q;

  // Memory ports
  nv_mem_if #(.AW(`EE_ADDR_W)) ee_bus ();
  nv_mem_if #(.AW(`ID_ADDR_W)) id_bus ();

  // Payload of command 0000 runs as one instruction
  assign f_adr     = pay_w[7:0];
  assign is_core   = pay_done && (cmd_q == `CMD_CORE);
  assign do_movlw  = is_core && (pay_w[15:8] == `OP_MOVLW);
  assign do_movwf  = is_core && (pay_w[15:8] == `OP_MOVWF);
  assign do_movf   = is_core && (pay_w[15:8] == `OP_MOVF);
  assign do_bsf    = is_core && (pay_w[15:12] == `OP_BSF);
  assign do_bcf    = is_core && (pay_w[15:12] == `OP_BCF);
  assign bit_mask  = 8'h01 << pay_w[11:9];
  assign sfr_we    = do_movwf | do_bsf | do_bcf;
  assign sfr_wdata = do_movwf ? w_q : (do_bsf ? (sfr_rd | bit_mask) : (sfr_rd & ~bit_mask));
  assign ctrl_sw   = sfr_we && (f_adr == `SFR_CTRL);
  assign ee_sel    = ctrl_q[`CTRL_PGM:`CTRL_CFG] == `SEL_DATA_EE;
  // Write-start is refused while write enable is clear or a write runs
  assign wr_set    = ctrl_sw && sfr_wdata[`CTRL_WR] && ctrl_q[`CTRL_WRITE_ENABLE_BIT] && !ctrl_q[`CTRL_WR];
  assign rd_go     = ctrl_sw && sfr_wdata[`CTRL_RD] && ee_sel && !ctrl_q[`CTRL_WR];

  // Special register read view
  always_comb begin
    case (f_adr)
      `SFR_CTRL:   sfr_rd = ctrl_q;
      `SFR_DATA:   sfr_rd = data_q;
      `SFR_ADDR_L: sfr_rd = addr_lo_q;
      `SFR_ADDR_H: sfr_rd = {6'h00, addr_hi_q};
      `SFR_TABLE_LATCH: sfr_rd = table_latch_q;
      `SFR_TP_L:   sfr_rd = ptr_q[7:0];
      `SFR_TP_H:   sfr_rd = ptr_q[15:8];
      `SFR_TP_U:   sfr_rd = {2'h0, ptr_q[21:16]};
      default:     sfr_rd = 8'h00;
    endcase
  end

  // Software may not clear write-start; only the sequencer ends it
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_sw) begin
      ctrl_d[`CTRL_PGM]  = sfr_wdata[`CTRL_PGM];
      ctrl_d[`CTRL_CFG]  = sfr_wdata[`CTRL_CFG];
      ctrl_d[`CTRL_WRITE_ENABLE_BIT] = sfr_wdata[`CTRL_WRITE_ENABLE_BIT];
    end
    if (wr_set) begin
      ctrl_d[`CTRL_WR] = 1'b1;
    end else if (wr_done) begin
      ctrl_d[`CTRL_WR] = 1'b0;
    end
  end

  // ****************************************************************
  // Table pointer and identification write buffer
  // ****************************************************************
  logic [7:0] wbuf_q [1 << `ID_ADDR_W];
  logic [2:0] id_cnt_q;
  logic       id_busy_q;
  logic       id_hit;
  logic       tbl_load;
  logic       prog_go;

  assign id_hit   = ptr_q[21:3] == `ID_BASE_TAG;
  assign tbl_load = pay_done && ((cmd_q == `CMD_TBL_WR_INC2) || (cmd_q == `CMD_TBL_WR_PROG));
  assign prog_go  = pay_done && (cmd_q == `CMD_TBL_WR_PROG) && ctrl_q[`CTRL_WRITE_ENABLE_BIT] &&
                    ctrl_q[`CTRL_PGM] && id_hit && !id_busy_q;
  // Protection never masks the identification bytes
  assign out_byte = (cmd_q == `CMD_SHIFT_OUT) ? table_latch_q :
                    (id_hit ? id_bus.rdata : 8'h00);

  // Working registers, address pair, data latch, table pointer
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_q       <= 8'h00;
      ctrl_q    <= `CTRL_RESET;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 2'h0;
      data_q    <= 8'h00;
      table_latch_q  <= 8'h00;
      ptr_q     <= 22'h000000;
      rd_pend_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      rd_pend_q <= rd_go;
      if (do_movlw) begin
        w_q <= f_adr;
      end else if (do_movf) begin
        w_q <= sfr_rd;
      end
      if (sfr_we && f_adr == `SFR_ADDR_L) begin
        addr_lo_q <= sfr_wdata;
      end
      if (sfr_we && f_adr == `SFR_ADDR_H) begin
        addr_hi_q <= sfr_wdata[1:0];
      end
      if (sfr_we && f_adr == `SFR_DATA) begin
        data_q <= sfr_wdata;
      end else if (rd_pend_q) begin
        data_q <= ee_bus.rdata;
      end
      if (sfr_we && f_adr == `SFR_TABLE_LATCH) begin
        table_latch_q <= sfr_wdata;
      end
      if (sfr_we && f_adr == `SFR_TP_L) begin
        ptr_q[7:0] <= sfr_wdata;
      end else if (sfr_we && f_adr == `SFR_TP_H) begin
        ptr_q[15:8] <= sfr_wdata;
      end else if (sfr_we && f_adr == `SFR_TP_U) begin
        ptr_q[21:16] <= sfr_wdata[5:0];
      end else if (pay_done && cmd_q == `CMD_TBL_WR_INC2) begin
        ptr_q <= ptr_q + `TP_STEP2;
      end else if (dummy_done && cmd_q == `CMD_TBL_RD_INC) begin
        ptr_q <= ptr_q + `TP_STEP1;
      end
    end
  end

  // Buffer takes LSB at the even byte, MSB at the odd; copy runs 8 cycles
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      id_cnt_q  <= 3'h0;
      id_busy_q <= 1'b0;
      for (int i = 0; i < (1 << `ID_ADDR_W); i++) begin
        wbuf_q[i] <= 8'h00;
      end
    end else begin
      if (tbl_load) begin
        wbuf_q[{ptr_q[2:1], 1'b0}] <= pay_w[7:0];
        wbuf_q[{ptr_q[2:1], 1'b1}] <= pay_w[15:8];
      end
      if (prog_go) begin
        id_busy_q <= 1'b1;
        id_cnt_q  <= 3'h0;
      end else if (id_busy_q) begin
        id_cnt_q  <= id_cnt_q + 3'h1;
        id_busy_q <= id_cnt_q != 3'h7;
      end
    end
  end

  // ****************************************************************
  // Data EEPROM write sequencer
  // ****************************************************************
  wr_state_t        wst_q;
  logic [2:0]       fall_cnt_q;
  logic [TMR_W-1:0] tmr_q;
  logic             ee_start;

  // Write lands on the fourth falling clock after write-start
  assign ee_start = (wst_q == WS_WAIT) && pgc_fall &&
                    (fall_cnt_q == `WR_START_FALLS - 3'h1);
  assign wr_done  = (wst_q == WS_BUSY) && (tmr_q == TMR_W'(WRITE_CYCLES - 1));

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wst_q      <= WS_IDLE;
      fall_cnt_q <= 3'h0;
      tmr_q      <= '0;
    end else begin
      case (wst_q)
        WS_IDLE: begin
          fall_cnt_q <= 3'h0;
          if (wr_set) begin
            wst_q <= WS_WAIT;
          end
        end
        WS_WAIT: begin
          if (ee_start) begin
            wst_q <= WS_BUSY;
            tmr_q <= '0;
          end else if (pgc_fall) begin
            fall_cnt_q <= fall_cnt_q + 3'h1;
          end
        end
        WS_BUSY: begin
          tmr_q <= tmr_q + 1'b1;
          if (wr_done) begin
            wst_q <= WS_IDLE;
          end
        end
        default: wst_q <= WS_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Memories
  // ****************************************************************
  // Only data-space selection writes the EEPROM; no erase step needed
  assign ee_bus.we    = ee_start && ee_sel;
  assign ee_bus.addr  = {addr_hi_q, addr_lo_q};
  assign ee_bus.wdata = data_q;
  assign id_bus.we    = id_busy_q;
  assign id_bus.addr  = id_busy_q ? id_cnt_q : ptr_q[2:0];
  assign id_bus.wdata = wbuf_q[id_cnt_q];

  nv_byte_mem #(.AW(`EE_ADDR_W)) u_ee_mem (
    .i_clk (i_ref_clk),
    .port  (ee_bus.mem)
  );

  nv_byte_mem #(.AW(`ID_ADDR_W)) u_id_mem (
    .i_clk (i_ref_clk),
    .port  (id_bus.mem)
  );

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic        req;
  logic        acc_wr;

  // One wait state: answer in the cycle after the request appears
  assign req    = (i_avs_read | i_avs_write) & wait_q;
  assign acc_wr = i_avs_write & ~wait_q;

  always_comb begin
    case (i_avs_address)
      `REG_CTRL:    rd_mux = {14'h0000, id_busy_q, wst_q != WS_IDLE, ctrl_q, 7'h00, link_on_q};
      `REG_EE_ADDR: rd_mux = {22'h000000, addr_hi_q, addr_lo_q};
      `REG_EE_DATA: rd_mux = {24'h000000, data_q};
      `REG_TBLPTR:  rd_mux = {10'h000, ptr_q};
      default:      rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q    <= 1'b1;
      rdata_q   <= 32'h00000000;
      link_on_q <= 1'b0;
    end else begin
      wait_q <= ~req;
      if (req) begin
        rdata_q <= rd_mux;
      end
      if (acc_wr && i_avs_address == `REG_CTRL) begin
        link_on_q <= i_avs_writedata[`BIT_LINK_ON];
      end
    end
  end

  assign o_avs_readdata        = rdata_q;
  assign o_avs_waitrequest     = wait_q;
  assign o_prog_serial_data    = sd_q;
  assign o_prog_serial_data_oe = oe_q;

endmodule

`default_nettype wire

// File: dv/nv_prog_core_chk.sv
/*
  Port checker of the programming engine: bus handshake and data pin turn.
  Assumes a bind onto nv_prog_core and one reference clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module nv_prog_core_chk (
  input wire logic        i_ref_clk,             // Clock
  input wire logic        i_rst_n,               // Reset, active low
  input wire logic        i_prog_serial_clock,   // Link clock
  input wire logic        i_prog_serial_data,    // Link data in
  input wire logic        o_prog_serial_data,    // Link data out
  input wire logic        o_prog_serial_data_oe, // Link data enable
  input wire logic [7:0]  i_avs_address,         // Bus address
  input wire logic        i_avs_read,            // Bus read
  input wire logic        i_avs_write,           // Bus write
  input wire logic [31:0] i_avs_writedata,       // Bus write data
  input wire logic [31:0] o_avs_readdata,        // Bus read data
  input wire logic        o_avs_waitrequest      // Bus stall
);
  // ****************************************
  // Properties
  // ****************************************
  // Reset cuts every property short, so no stale history leaks across it
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  AST_ONE_WAIT: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");
  AST_WAIT_PULSE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("bus answer too long");
  AST_NO_SPURIOUS: assert property (!o_avs_waitrequest |-> $past(i_avs_read) || $past(i_avs_write))
    else $error("answer without request");
  AST_UNMAPPED_ZERO: assert property (i_avs_read && o_avs_waitrequest && i_avs_address > 8'h0C |=>
    o_avs_readdata == 32'h0) else $error("unmapped read not zero");
  AST_BUSY_HOLDS_START: assert property ($fell(o_avs_waitrequest) && $past(i_avs_read) &&
    $past(i_avs_address) == 8'h00 && o_avs_readdata[16] |-> o_avs_readdata[9]) else $error("start clear while busy");
  AST_TURN_LOW: assert property ($rose(o_prog_serial_data_oe) |-> !i_prog_serial_clock &&
    !$past(i_prog_serial_clock, 3)) else $error("drive began with clock high");
  AST_DRIVE_SPAN: assert property ($rose(o_prog_serial_data_oe) |=> o_prog_serial_data_oe [*8])
    else $error("drive too short");
  AST_RELEASE_LOW: assert property ($fell(o_prog_serial_data_oe) |-> !i_prog_serial_clock)
    else $error("drive ended with clock high");
  // Main scenarios reached
  cover property ($rose(o_prog_serial_data_oe));
  cover property (i_avs_write && !o_avs_waitrequest);
  cover property ($fell(o_avs_waitrequest) && o_avs_readdata[16]);
endmodule
`default_nettype wire

// File: dv/prog_link_model.sv
/*
  Programmer model: drives link clock and data, reads shifted bytes.
  Assumes the bench resolves the data pin and calls the tasks.
*/
`timescale 1ns/10ps
`default_nettype none
module prog_link_model (
  input  wire logic i_clk,  // Bench clock
  input  wire logic i_pin,  // Resolved data pin
  output logic      o_clk,  // Link clock, still between frames
  output logic      o_data  // Data drive
);
  // ****************************************
  // Link tasks
  // ****************************************
  initial begin
    o_clk = 1'b0;
    o_data = 1'b0;
  end
  // One link period of 9 bench clocks; data set with the rise
  task automatic pulse(input logic b);
    @(posedge i_clk);
    o_data <= b;
    o_clk <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_clk <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  // Command then payload, low bit first
  task automatic frame(input logic [3:0] c, input logic [15:0] p);
    logic [19:0] w;
    w = {p, c};
    for (int i = 0; i < 20; i++) pulse(w[i]);
    repeat (4) @(posedge i_clk);
  endtask
  // Command, 8 dummy clocks, turn-round with clock low, then 8 bits out
  task automatic read_byte(input logic [3:0] c, output logic [7:0] v);
    logic [11:0] w;
    w = {8'h00, c};
    for (int i = 0; i < 12; i++) pulse(w[i]);
    o_data <= ~o_data; // Released line shows the opposite level, not a stale bit
    repeat (8) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      o_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_clk <= 1'b0;
      repeat (3) @(posedge i_clk);
      v[i] = i_pin;
      @(posedge i_clk);
    end
    repeat (4) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// File: dv/serial_eeprom_and_id_programming_test.sv
/*
  Self-checking bench of the programming engine with a programmer model.
  Assumes design, map header, checker and model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "nv_prog_map.svh"
module serial_eeprom_and_id_programming_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        waitreq, prog_serial_clock, pgd_prog, pgd_dev, pgd_oe;
  wire         pgd_pin;
  int          err_count = 0;
  int          compares = 0;
  int          seed = 94504;
  logic [7:0]  ee_exp;
  logic [7:0]  exp_q[$];
  // ****************************************
  // Clock, pin and instances
  // ****************************************
  assign pgd_pin = pgd_oe ? pgd_dev : pgd_prog; // Device wins while driving
  always #20 clk = ~clk;
  nv_prog_core #(.WRITE_CYCLES(40)) i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_prog_serial_clock(prog_serial_clock),
    .i_prog_serial_data(pgd_pin), .o_prog_serial_data(pgd_dev), .o_prog_serial_data_oe(pgd_oe),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(waitreq));
  prog_link_model i_link (.i_clk(clk), .i_pin(pgd_pin), .o_clk(prog_serial_clock), .o_data(pgd_prog));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic core(input logic [15:0] p);
    i_link.frame(`CMD_CORE, p);
  endtask
  task automatic ctl(input logic s, input logic [2:0] b);
    core({s ? `OP_BSF : `OP_BCF, b, 1'b0, `SFR_CTRL});
  endtask
  task automatic set_ptr();
    core({`OP_MOVLW, 8'h20});
    core({`OP_MOVWF, `SFR_TP_U});
    core({`OP_MOVLW, 8'h00});
    core({`OP_MOVWF, `SFR_TP_H});
    core({`OP_MOVWF, `SFR_TP_L});
  endtask
  // One full byte sequence; en low leaves write enable clear
  task automatic ee_byte(input logic [9:0] a, input logic [7:0] d, input logic en);
    logic [31:0] q;
    ctl(1'b0, 3'h7);
    ctl(1'b0, 3'h6);
    core({`OP_MOVLW, a[7:0]});
    core({`OP_MOVWF, `SFR_ADDR_L});
    core({`OP_MOVLW, 6'h00, a[9:8]});
    core({`OP_MOVWF, `SFR_ADDR_H});
    core({`OP_MOVLW, d});
    core({`OP_MOVWF, `SFR_DATA});
    if (en) ctl(1'b1, 3'h2);
    ctl(1'b1, 3'h1);
    // Idle frame sent bit by bit: only its fourth fall may start the write
    for (int i = 0; i < 20; i++) begin
      i_link.pulse(1'b0);
      if (i < 4) begin
        repeat (4) @(posedge clk);
        bus(1'b0, `REG_CTRL, 32'h0, q);
        chk("ctrl", {15'h0, en, 5'h0, en, en, 9'h001}, q);
      end
    end
    core({`OP_MOVF, `SFR_CTRL});
    core({`OP_MOVWF, `SFR_TABLE_LATCH});
    i_link.read_byte(`CMD_SHIFT_OUT, q[7:0]);
    chk("poll", {29'h0, en, 2'h0}, {24'h0, q[7:0]});
    ctl(1'b0, 3'h2);
    core({`OP_MOVLW, 8'h00});
    core({`OP_MOVWF, `SFR_DATA});
    ctl(1'b1, 3'h0);
    if (en) ee_exp = d;
    bus(1'b0, `REG_EE_DATA, 32'h0, q);
    chk("eeprom", {24'h0, ee_exp}, q);
  endtask
  task automatic print_verdict();
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    logic [31:0] q;
    logic [31:0] r;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, `REG_CTRL, 32'h0, q);
    chk("ctrl reset", 32'h0, q);
    bus(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", 32'h0, q);
    bus(1'b1, `REG_CTRL, 32'h1, q);
    r = $random(seed);
    // Same place written, rewritten, then refused without write enable
    for (int k = 0; k < 3; k++) ee_byte(r[9:0], r[17:10] ^ k[7:0], k != 2);
    ctl(1'b1, 3'h7);
    ctl(1'b1, 3'h2);
    set_ptr();
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      exp_q.push_back(r[7:0]);
      exp_q.push_back(r[15:8]);
      i_link.frame(k == 3 ? `CMD_TBL_WR_PROG : `CMD_TBL_WR_INC2, r[15:0]);
    end
    core(16'h0000);
    ctl(1'b0, 3'h2);
    set_ptr();
    for (int k = 0; k < 8; k++) begin
      i_link.read_byte(`CMD_TBL_RD_INC, q[7:0]);
      chk("id byte", {24'h0, exp_q.pop_front()}, {24'h0, q[7:0]});
    end
    bus(1'b0, `REG_TBLPTR, 32'h0, q);
    chk("pointer", 32'h00200008, q);
    print_verdict();
  end
  // Bound well above the roughly 15000 cycles the sequence needs
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule
bind nv_prog_core nv_prog_core_chk i_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_prog_serial_clock(i_prog_serial_clock), .i_prog_serial_data(i_prog_serial_data),
  .o_prog_serial_data(o_prog_serial_data), .o_prog_serial_data_oe(o_prog_serial_data_oe),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));
`default_nettype wire
